// [dual_buffer_tx_dma.sv]
// Dual-buffer transmit DMA channel with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

// Contract
// - On bus error, end the current memory cycle and drop the bus request.
// - On bus error, restore pointer, count and staged bytes from burst start.
// - Nonzero retry count at bus error: decrement and retry automatically.
// - Zero retry count at bus error: flag bus error and suspend until cleared.
// - Separate A and B transmit descriptors, each with its own ownership flag.
// - Ownership flag one means device holds buffer, zero means host holds it.
// - Nobody seizes a buffer; only the holder hands it to the other party.
// - Separate next-buffer indicators for transmit and receive.
// - Accepting a buffer flips next; finishing returns it, then accepts other.
// - First buffer of a frame marks start of frame on its first byte.
// - End-of-frame buffer tags its last byte so CRC and closing are added; an appending buffer A tags no byte.
// - Buffer without end-of-frame continues the frame without restart; after an appending buffer A the next buffer starts a new frame.
// - Host supplies end-of-frame on transmit, device sets it on receive.
// - Device works on copies of start and length, registers stay unchanged.
// - CRC enable and polynomial select travel with every byte of the buffer.
// - Buffer with interrupt-request bit raises a host interrupt when done.
// - Word fetch when aligned; misaligned chained buffer falls back to bytes.
// - Append only on buffer A and only in asynchronous mode.
// - Full 16-bit length write during append triggers more transmission.
// - Append finish command completes buffer A, clears ownership, interrupts.
// - One ownership period moves at most the burst size of bytes.
module dual_buffer_tx_dma
  import tx_dma_pkg::*;
#(
  parameter int BURST_BYTES = 16
) (
  input  wire logic        ref_clk_i,         // System clock
  input  wire logic        srst_i,            // Synchronous reset, high
  input  wire logic [7:0]  avs_address_i,     // Register byte address
  input  wire logic        avs_read_i,        // Register read
  input  wire logic        avs_write_i,       // Register write
  input  wire logic [31:0] avs_writedata_i,   // Register write data
  input  wire logic [3:0]  avs_byteenable_i,  // Write byte lanes
  output logic      [31:0] avs_readdata_o,    // Register read data
  output logic             avs_waitrequest_o, // Slave stall
  output logic             mem_req_o,         // Memory bus request
  input  wire logic        mem_grant_i,       // Memory bus granted
  output logic             mem_rd_o,          // Memory read strobe
  output logic             mem_word_o,        // Two-byte transfer
  output logic      [31:0] mem_addr_o,        // Memory byte address
  input  wire logic [15:0] mem_rdata_i,       // Memory read data
  input  wire logic        mem_ack_i,         // Memory cycle done
  input  wire logic        mem_err_i,         // Memory bus error
  output tx_byte_type      tx_byte_o,         // Byte to transmitter
  output logic             tx_valid_o,        // Byte valid
  input  wire logic        tx_ready_i,        // Transmitter accepts
  input  wire logic        rx_buf_switch_i,   // Receiver changed buffer
  output logic             buf_irq_o,         // Buffer done event
  output logic             berr_irq_o         // Bus error event
);

  localparam logic [4:0] BURST = 5'(BURST_BYTES);
  localparam logic [4:0] ONE5  = 5'h01;
  localparam logic [4:0] TWO5  = 5'h02;

  typedef struct packed {
    dma_state_type          st;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic [31:0]            a_start;
    logic [31:0]            b_start;
    logic [15:0]            a_len;
    logic [15:0]            b_len;
    logic [STATE_W-1:0]     a_state;
    logic [STATE_W-1:0]     b_state;
    logic [POLY_W-1:0]      poly;
    logic                   finish;
    logic                   async_mode;
    logic [7:0]             retry;
    logic [CAUSE_W-1:0]     cause;
    logic                   tx_next;
    logic                   rx_next;
    logic                   busy;
    logic                   cur_b;
    logic                   new_frame;
    logic                   sof_pend;
    logic [31:0]            ptr;
    logic [15:0]            clen;
    logic [15:0]            sent;
    logic                   phase;
    logic                   mis;
    logic [31:0]            snap_ptr;
    logic [15:0]            snap_sent;
    logic                   snap_phase;
    logic [15:0][7:0]       stage;
    logic [4:0]             scnt;
    logic [4:0]             didx;
    mem_cmd_type            mem;
    tx_byte_type            txb;
    logic                   tx_valid;
    logic                   buf_irq;
    logic                   berr_irq;
  } state_type;

  state_type r;
  state_type next_r;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [31:0] read_mux(input state_type s, input logic [7:0] a);
    logic [31:0] v;
    v = RESET_WORD;
    case (a)
      OFS_A_START: v = s.a_start;
      OFS_A_LEN:   v[15:0] = s.a_len;
      OFS_A_STATE: v[STATE_W-1:0] = s.a_state;
      OFS_B_START: v = s.b_start;
      OFS_B_LEN:   v[15:0] = s.b_len;
      OFS_B_STATE: v[STATE_W-1:0] = s.b_state;
      OFS_POLY:    v[POLY_W-1:0] = s.poly;
      OFS_CMD:     v[CMD_FINISH] = s.finish;
      OFS_CUR_PTR: v = s.ptr;
      OFS_DBS: begin
        v[DBS_TX_NEXT] = s.tx_next;
        v[DBS_BUSY]    = s.busy;
        v[DBS_RX_NEXT] = s.rx_next;
        v[DBS_SUSP]    = (s.st == S_SUSP);
      end
      OFS_CAUSE:   v[CAUSE_W-1:0] = s.cause;
      OFS_RETRY:   v[7:0] = s.retry;
      OFS_MODE:    v[MODE_ASYNC] = s.async_mode;
      default:     v = RESET_WORD;
    endcase
    return v;
  endfunction : read_mux

  logic [31:0]        wmerge;
  logic               wr;
  logic               appending;
  logic [STATE_W-1:0] cur_state;
  logic [15:0]        rem;
  logic               word_ok;
  logic [4:0]         step;
  logic               last_out;

  always_comb begin
    next_r    = r;
    wmerge    = merge(read_mux(r, avs_address_i), avs_writedata_i, avs_byteenable_i);
    wr        = avs_write_i && !r.waitreq;
    appending = r.a_state[APPEND_BIT] && r.async_mode && !r.cur_b;
    cur_state = r.cur_b ? r.b_state : r.a_state;
    rem       = r.clen - r.sent;
    word_ok   = !r.mis && !r.ptr[0] && (rem >= 16'h0002) && (r.scnt <= BURST - TWO5);
    step      = r.mem.word ? TWO5 : ONE5;
    last_out  = (r.didx + ONE5 == r.scnt) && (rem == 16'h0000);
    next_r.buf_irq  = 1'b0;
    next_r.berr_irq = 1'b0;

    // Slave: one wait cycle, read data captured on the same edge that drops waitrequest
    if ((avs_read_i || avs_write_i) && r.waitreq) begin
      next_r.waitreq = 1'b0;
      next_r.rdata   = read_mux(r, avs_address_i);
    end else begin
      next_r.waitreq = 1'b1;
    end

    if (wr) begin
      case (avs_address_i)
        OFS_A_START: begin
          if (!(r.a_state[APPEND_BIT] && r.a_state[OWN_BIT])) begin
            next_r.a_start = wmerge;
          end
        end
        OFS_A_LEN: begin
          if (!appending || !r.a_state[OWN_BIT] || (avs_byteenable_i[1:0] == 2'h3)) begin
            next_r.a_len = wmerge[15:0];
          end
        end
        OFS_A_STATE: begin
          if (!r.a_state[OWN_BIT]) begin
            next_r.a_state = wmerge[STATE_W-1:0];
          end
        end
        OFS_B_START: next_r.b_start = wmerge;
        OFS_B_LEN:   next_r.b_len = wmerge[15:0];
        OFS_B_STATE: begin
          if (!r.b_state[OWN_BIT]) begin
            next_r.b_state = wmerge[STATE_W-1:0];
          end
        end
        OFS_POLY:  next_r.poly = wmerge[POLY_W-1:0];
        OFS_CMD: begin
          if (avs_byteenable_i[0] && avs_writedata_i[CMD_FINISH]) begin
            next_r.finish = 1'b1;
          end
        end
        OFS_CAUSE: begin
          if (avs_byteenable_i[0]) begin
            next_r.cause = r.cause & ~avs_writedata_i[CAUSE_W-1:0];
          end
        end
        OFS_RETRY: next_r.retry = wmerge[7:0];
        OFS_MODE:  next_r.async_mode = wmerge[MODE_ASYNC];
        default: begin
        end
      endcase
    end

    if (rx_buf_switch_i) begin
      next_r.rx_next = ~r.rx_next;
    end

    case (r.st)
      S_IDLE: begin
        next_r.mem = '0;
        if (r.tx_next ? r.b_state[OWN_BIT] : r.a_state[OWN_BIT]) begin
          next_r.cur_b   = r.tx_next;
          next_r.tx_next = ~r.tx_next;
          next_r.st      = S_LOAD;
        end
      end
      S_LOAD: begin
        next_r.ptr  = r.cur_b ? r.b_start : r.a_start;
        next_r.clen = r.cur_b ? r.b_len : r.a_len;
        next_r.sent = 16'h0000;
        next_r.busy = 1'b1;
        if (r.new_frame) begin
          next_r.sof_pend = 1'b1;
          next_r.phase    = 1'b0;
          next_r.mis      = r.cur_b ? r.b_start[0] : r.a_start[0];
        end else begin
          next_r.mis = (r.cur_b ? r.b_start[0] : r.a_start[0]) != r.phase;
        end
        next_r.new_frame = 1'b0;
        next_r.st        = S_BREQ;
      end
      S_BREQ: begin
        if (rem == 16'h0000) begin
          next_r.mem.req = 1'b0;
          next_r.st      = appending ? S_APPEND : S_END;
        end else begin
          next_r.mem.req = 1'b1;
          if (r.mem.req && mem_grant_i) begin
            next_r.snap_ptr   = r.ptr;
            next_r.snap_sent  = r.sent;
            next_r.snap_phase = r.phase;
            next_r.scnt       = 5'h00;
            next_r.st         = S_XFER;
          end
        end
      end
      S_XFER: begin
        if (r.mem.rd && mem_err_i) begin
          next_r.mem   = '0;
          next_r.ptr   = r.snap_ptr;
          next_r.sent  = r.snap_sent;
          next_r.phase = r.snap_phase;
          next_r.scnt  = 5'h00;
          if (r.retry != 8'h00) begin
            next_r.retry = r.retry - 8'h01;
            next_r.st    = S_BREQ;
          end else begin
            next_r.berr_irq = 1'b1;
            next_r.st       = S_SUSP;
          end
        end else if (r.mem.rd && mem_ack_i) begin
          next_r.mem.rd = 1'b0;
          if (r.mem.word) begin
            next_r.stage[r.scnt[3:0]]        = mem_rdata_i[15:8];
            next_r.stage[r.scnt[3:0] + 4'h1] = mem_rdata_i[7:0];
          end else begin
            next_r.stage[r.scnt[3:0]] = r.ptr[0] ? mem_rdata_i[7:0] : mem_rdata_i[15:8];
          end
          next_r.ptr   = r.ptr + 32'(step);
          next_r.sent  = r.sent + 16'(step);
          next_r.phase = r.phase ^ !r.mem.word;
          next_r.scnt  = r.scnt + step;
          if ((r.scnt + step >= BURST) || (rem == 16'(step))) begin
            next_r.mem.req = 1'b0;
            next_r.didx    = 5'h00;
            next_r.st      = S_DRAIN;
          end
        end else if (!r.mem.rd) begin
          next_r.mem.rd   = 1'b1;
          next_r.mem.addr = r.ptr;
          next_r.mem.word = word_ok;
        end
      end
      S_DRAIN: begin
        if (!r.tx_valid || tx_ready_i) begin
          if (r.didx < r.scnt) begin
            next_r.txb.data   = r.stage[r.didx[3:0]];
            next_r.txb.sof    = r.sof_pend;
            next_r.txb.eof    = last_out && cur_state[EOF_BIT] && !appending;
            next_r.txb.crc_en = cur_state[CRC_BIT];
            next_r.txb.poly   = r.poly;
            next_r.tx_valid   = 1'b1;
            next_r.sof_pend   = 1'b0;
            next_r.didx       = r.didx + ONE5;
          end else begin
            next_r.tx_valid = 1'b0;
            next_r.st       = S_BREQ;
          end
        end
      end
      S_APPEND: begin
        if (r.a_len != r.clen) begin
          next_r.clen = r.a_len;
          next_r.st   = S_BREQ;
        end else if (r.finish) begin
          next_r.st = S_END;
        end
      end
      S_END: begin
        next_r.busy   = 1'b0;
        next_r.finish = 1'b0;
        if (r.cur_b) begin
          next_r.b_state[OWN_BIT]  = 1'b0;
          next_r.b_state[DONE_BIT] = 1'b1;
        end else begin
          next_r.a_state[OWN_BIT]  = 1'b0;
          next_r.a_state[DONE_BIT] = 1'b1;
        end
        next_r.new_frame = cur_state[EOF_BIT] || appending;
        next_r.buf_irq   = cur_state[IRQ_BIT] || appending;
        next_r.st        = S_IDLE;
      end
      S_SUSP: begin
        next_r.mem = '0;
        if (!r.cause[CAUSE_BERR]) begin
          next_r.st = S_BREQ;
        end
      end
      default: next_r.st = S_IDLE;
    endcase

    // Hardware events set after the host clear, so a coincident event wins
    if (r.st == S_END) begin
      next_r.cause[CAUSE_DONE] = 1'b1;
      next_r.cause[CAUSE_EOF]  = next_r.cause[CAUSE_EOF] | cur_state[EOF_BIT];
    end
    if (next_r.berr_irq) begin
      next_r.cause[CAUSE_BERR] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r            <= '0;
      r.st         <= S_IDLE;
      r.waitreq    <= 1'b1;
      r.retry      <= RESET_RETRY;
      r.new_frame  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign mem_req_o         = r.mem.req;
  assign mem_rd_o          = r.mem.rd;
  assign mem_word_o        = r.mem.word;
  assign mem_addr_o        = r.mem.addr;
  assign tx_byte_o         = r.txb;
  assign tx_valid_o        = r.tx_valid;
  assign buf_irq_o         = r.buf_irq;
  assign berr_irq_o        = r.berr_irq;

endmodule : dual_buffer_tx_dma

`default_nettype wire

// [dual_buffer_tx_dma_asserts.sv]
// Port-level checker of the dual-buffer transmit DMA block
`timescale 1ns/100ps
`default_nettype none
module dual_buffer_tx_dma_asserts
  import tx_dma_pkg::*;
#(
  parameter int BURST_BYTES = 16
) (
  input wire logic        ref_clk_i,         // Clock
  input wire logic        srst_i,            // Reset
  input wire logic        avs_read_i,        // Register read
  input wire logic        avs_write_i,       // Register write
  input wire logic        avs_waitrequest_o, // Slave stall
  input wire logic        mem_req_o,         // Bus request
  input wire logic        mem_rd_o,          // Read strobe
  input wire logic        mem_word_o,        // Two-byte read
  input wire logic [31:0] mem_addr_o,        // Read address
  input wire logic        mem_ack_i,         // Cycle done
  input wire logic        mem_err_i,         // Bus error
  input wire tx_byte_type tx_byte_o,         // Stream byte
  input wire logic        tx_valid_o,        // Stream valid
  input wire logic        tx_ready_i,        // Stream ready
  input wire logic        buf_irq_o,         // Buffer event
  input wire logic        berr_irq_o         // Bus error event
);
  logic [7:0] burst_cnt;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Bytes moved in the current ownership period
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !mem_req_o)
      burst_cnt <= 8'h00;
    else if (mem_rd_o && mem_ack_i && !mem_err_i)
      burst_cnt <= burst_cnt + (mem_word_o ? 8'h02 : 8'h01);
  end

  req_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("register access not answered");
  wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  rd_owned_a: assert property (mem_rd_o |-> mem_req_o)
    else $error("read strobe without bus request");
  err_release_a: assert property (mem_rd_o && mem_err_i |=> !mem_rd_o && !mem_req_o)
    else $error("bus kept after bus error");
  word_even_a: assert property (mem_rd_o && mem_word_o |-> !mem_addr_o[0])
    else $error("word read at odd address");
  rd_hold_a: assert property (mem_rd_o && !mem_ack_i && !mem_err_i
    |=> mem_rd_o && $stable(mem_addr_o) && $stable(mem_word_o))
    else $error("read cycle changed before answer");
  burst_limit_a: assert property (burst_cnt <= BURST_BYTES)
    else $error("too many bytes in one ownership period");
  stream_hold_a: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_byte_o)) else $error("stream byte dropped");
  fetch_first_a: assert property (mem_rd_o |-> !tx_valid_o)
    else $error("bytes sent before burst completed");
  irq_pulse_a: assert property (buf_irq_o |=> !buf_irq_o)
    else $error("buffer event longer than one cycle");
  berr_idle_a: assert property (berr_irq_o |-> !mem_req_o ##1 !berr_irq_o)
    else $error("bus error event with bus held");
endmodule : dual_buffer_tx_dma_asserts

bind dual_buffer_tx_dma dual_buffer_tx_dma_asserts #(.BURST_BYTES(BURST_BYTES)) i_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .mem_req_o(mem_req_o), .mem_rd_o(mem_rd_o), .mem_word_o(mem_word_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
  .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .buf_irq_o(buf_irq_o), .berr_irq_o(berr_irq_o));
`default_nettype wire

// [dual_buffer_tx_dma_tb_top.sv]
// Self-checking testbench of the dual-buffer transmit DMA block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dual_buffer_tx_dma_tb_top;
  import tx_dma_pkg::*;
  logic        ref_clk_i = 0, srst_i = 1, rd = 0, wr = 0, rdy = 0, rxs = 0, inj = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  be = 4'hf;
  logic [31:0] wd = 32'h0, q, rdat, maddr;
  logic        wreq, mreq, mrd, mword, grant, ack, err, bufirq, berr, valid;
  logic [15:0] mdat;
  tx_byte_type tb, sq[$];
  int          fail_count = 0, cmp_count = 0, cyc = 0, nirq = 0, nberr = 0;

  dual_buffer_tx_dma #(.BURST_BYTES(16)) i_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .mem_req_o(mreq),
    .mem_grant_i(grant), .mem_rd_o(mrd), .mem_word_o(mword), .mem_addr_o(maddr),
    .mem_rdata_i(mdat), .mem_ack_i(ack), .mem_err_i(err), .tx_byte_o(tb),
    .tx_valid_o(valid), .tx_ready_i(rdy), .rx_buf_switch_i(rxs),
    .buf_irq_o(bufirq), .berr_irq_o(berr));

  tx_mem_model i_mem (
    .clk_i(ref_clk_i), .srst_i(srst_i), .req_i(mreq), .rd_i(mrd), .addr_i(maddr),
    .inj_i(inj), .grant_o(grant), .ack_o(ack), .err_o(err), .rdata_o(mdat));

  always #5 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    rdy <= ($urandom % 4) != 0;
    if (valid && rdy) sq.push_back(tb);
    if (bufirq) nirq++;
    if (berr) nberr++;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    @(posedge ref_clk_i);
    while (wreq !== 1'b0) @(posedge ref_clk_i);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus

  task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, q)
  endtask : rdchk

  function automatic logic [7:0] eb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : eb

  task automatic setb(logic s, logic [31:0] st, logic [15:0] ln, logic [5:0] fl);
    bus(1'b1, s ? OFS_B_START : OFS_A_START, st);
    bus(1'b1, s ? OFS_B_LEN : OFS_A_LEN, {16'h0, ln});
    bus(1'b1, s ? OFS_B_STATE : OFS_A_STATE, {26'h0, fl});
  endtask : setb

  task automatic chk(logic [31:0] st, int ln, logic sf, logic ef, logic cr, logic [1:0] pl);
    tx_byte_type b;
    for (int i = 0; i < ln; i++) begin
      b = sq.pop_front();
      `CHK("data", eb(st + i), b.data)
      `CHK("sof", sf && i == 0, b.sof)
      `CHK("eof", ef && i == ln - 1, b.eof)
      `CHK("crc", {cr, pl}, {b.crc_en, b.poly})
    end
  endtask : chk

  initial begin
    logic [31:0] st[2];
    logic [15:0] ln[2];
    logic [5:0]  fl[2];
    logic        nxt, sofp, anyeof, s;
    logic [1:0]  pl;
    int          nb, tot, ei;
    void'($urandom(47));
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rdchk("a state", OFS_A_STATE, 32'h0);
    rdchk("b state", OFS_B_STATE, 32'h0);
    rdchk("dbs", OFS_DBS, 32'h0);
    rdchk("unmapped", 8'h3c, 32'h0);
    `CHK("idle req", 1'b0, mreq)
    @(posedge ref_clk_i) rxs <= 1'b1;
    @(posedge ref_clk_i) rxs <= 1'b0;
    rdchk("rx next", OFS_DBS, 32'h4);
    pl = 2'($urandom);
    bus(1'b1, OFS_POLY, {30'h0, pl});
    nxt = 0; sofp = 1; ei = 0;
    for (int it = 0; it < 4; it++) begin
      nb = 1 + it % 2; tot = 0; anyeof = 0;
      if (it == 1) bus(1'b1, OFS_RETRY, 32'h1);
      if (it % 2 == 1) inj <= 1'b1;
      for (int k = 0; k < nb; k++) begin
        st[k] = $urandom; ln[k] = 16'(1 + $urandom % 40);
        fl[k] = {1'b0, 3'($urandom), 2'b01};
        setb(nxt ^ (k == 1), st[k], ln[k], fl[k]);
        tot += ln[k]; ei += fl[k][IRQ_BIT]; anyeof |= fl[k][EOF_BIT];
      end
      if (it == 3) begin
        while (nberr == 0) @(posedge ref_clk_i);
        bus(1'b0, OFS_DBS, 32'h0);
        `CHK("suspended", 1'b1, q[DBS_SUSP])
        rdchk("berr cause", OFS_CAUSE, 32'h4);
        bus(1'b1, OFS_CAUSE, 32'h4);
      end
      waitn(tot);
      inj <= 1'b0;
      for (int k = 0; k < nb; k++) begin
        chk(st[k], ln[k], sofp, fl[k][EOF_BIT], fl[k][CRC_BIT], pl);
        sofp = fl[k][EOF_BIT];
      end
      s = nxt ^ (nb == 2);
      do bus(1'b0, s ? OFS_B_STATE : OFS_A_STATE, 32'h0); while (q[OWN_BIT] !== 1'b0);
      for (int k = 0; k < nb; k++)
        rdchk("state", (nxt ^ (k == 1)) ? OFS_B_STATE : OFS_A_STATE,
              {26'h0, fl[k] & 6'h3e | 6'h02});
      rdchk("len kept", s ? OFS_B_LEN : OFS_A_LEN, {16'h0, ln[nb - 1]});
      rdchk("start kept", s ? OFS_B_START : OFS_A_START, st[nb - 1]);
      nxt = nxt ^ (nb == 1);
      bus(1'b0, OFS_DBS, 32'h0);
      `CHK("tx next", nxt, q[DBS_TX_NEXT])
      `CHK("irqs", ei, nirq)
      rdchk("cause", OFS_CAUSE, {30'h0, anyeof, 1'b1});
      bus(1'b1, OFS_CAUSE, 32'h3);
      if (it == 1) rdchk("retry", OFS_RETRY, 32'h0);
      if (it == 1) `CHK("no berr", 0, nberr)
    end
    bus(1'b1, OFS_MODE, 32'h1);
    st[0] = $urandom; ln[0] = 16'(1 + $urandom % 20); ln[1] = ln[0] + 16'(1 + $urandom % 20);
    setb(1'b0, st[0], ln[0], 6'h21);
    waitn(ln[0]);
    bus(1'b1, OFS_A_STATE, 32'h0);
    bus(1'b1, OFS_A_START, ~st[0]);
    rdchk("owned", OFS_A_STATE, 32'h21);
    rdchk("append start", OFS_A_START, st[0]);
    be <= 4'h1;
    bus(1'b1, OFS_A_LEN, {16'h0, ln[1]});
    be <= 4'hf;
    rdchk("half len", OFS_A_LEN, {16'h0, ln[0]});
    bus(1'b1, OFS_A_LEN, {16'h0, ln[1]});
    waitn(ln[1]);
    bus(1'b1, OFS_CMD, 32'h1);
    do bus(1'b0, OFS_A_STATE, 32'h0); while (q[OWN_BIT] !== 1'b0);
    chk(st[0], ln[1], sofp, 1'b0, 1'b0, pl);
    `CHK("append irq", ei + 1, nirq)
    report_and_stop();
  end

  task automatic waitn(int n);
    while (sq.size() < n) @(posedge ref_clk_i);
  endtask : waitn
endmodule : dual_buffer_tx_dma_tb_top
`default_nettype wire

// [tx_dma_pkg.sv]
// Constants and types of the dual-buffer transmit DMA block
package tx_dma_pkg;

  // Register byte offsets on the slave port
  localparam logic [7:0] OFS_A_START = 8'h00;
  localparam logic [7:0] OFS_A_LEN   = 8'h04;
  localparam logic [7:0] OFS_A_STATE = 8'h08;
  localparam logic [7:0] OFS_B_START = 8'h0c;
  localparam logic [7:0] OFS_B_LEN   = 8'h10;
  localparam logic [7:0] OFS_B_STATE = 8'h14;
  localparam logic [7:0] OFS_POLY    = 8'h18;
  localparam logic [7:0] OFS_CMD     = 8'h1c;
  localparam logic [7:0] OFS_CUR_PTR = 8'h20;
  localparam logic [7:0] OFS_DBS     = 8'h24;
  localparam logic [7:0] OFS_CAUSE   = 8'h28;
  localparam logic [7:0] OFS_RETRY   = 8'h2c;
  localparam logic [7:0] OFS_MODE    = 8'h30;

  // Buffer state register fields
  localparam int STATE_W    = 6;
  localparam int OWN_BIT    = 0;
  localparam int DONE_BIT   = 1;
  localparam int EOF_BIT    = 2;
  localparam int CRC_BIT    = 3;
  localparam int IRQ_BIT    = 4;
  localparam int APPEND_BIT = 5;

  // Interrupt cause fields
  localparam int CAUSE_W    = 3;
  localparam int CAUSE_DONE = 0;
  localparam int CAUSE_EOF  = 1;
  localparam int CAUSE_BERR = 2;

  // Buffer-state summary fields
  localparam int DBS_TX_NEXT = 0;
  localparam int DBS_BUSY    = 1;
  localparam int DBS_RX_NEXT = 2;
  localparam int DBS_SUSP    = 3;

  localparam int CMD_FINISH = 0;
  localparam int MODE_ASYNC = 0;
  localparam int POLY_W     = 2;

  localparam logic [7:0]  RESET_RETRY = 8'h00;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_LOAD   = 3'b001,
    S_BREQ   = 3'b010,
    S_XFER   = 3'b011,
    S_DRAIN  = 3'b100,
    S_END    = 3'b101,
    S_APPEND = 3'b110,
    S_SUSP   = 3'b111
  } dma_state_type;

  typedef struct packed {
    logic [7:0]        data;
    logic              sof;
    logic              eof;
    logic              crc_en;
    logic [POLY_W-1:0] poly;
  } tx_byte_type;

  typedef struct packed {
    logic        req;
    logic        rd;
    logic        word;
    logic [31:0] addr;
  } mem_cmd_type;

endpackage : tx_dma_pkg

// [tx_mem_model.sv]
// Host memory bus model with random grant and answer delays
`timescale 1ns/100ps
`default_nettype none
module tx_mem_model (
  input  wire logic        clk_i,   // Clock
  input  wire logic        srst_i,  // Reset
  input  wire logic        req_i,   // Bus request
  input  wire logic        rd_i,    // Read strobe
  input  wire logic [31:0] addr_i,  // Byte address
  input  wire logic        inj_i,   // Next answer is an error, once
  output logic             grant_o, // Bus granted
  output logic             ack_o,   // Cycle done
  output logic             err_o,   // Bus error
  output logic      [15:0] rdata_o  // Even byte high
);
  logic done;
  logic spent;

  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mem_byte

  always @(posedge clk_i) begin
    if (srst_i) begin
      grant_o <= 1'b0;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      done    <= 1'b0;
      spent   <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      // One error per raising of the inject input
      spent   <= inj_i && (spent || err_o);
      grant_o <= req_i && (grant_o || $urandom_range(1, 0) == 1);
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      // Released data lines never repeat the last value
      rdata_o <= ~rdata_o;
      if (!rd_i)
        done <= 1'b0;
      else if (!done && $urandom_range(2, 0) == 0) begin
        done    <= 1'b1;
        ack_o   <= !(inj_i && !spent);
        err_o   <= inj_i && !spent;
        rdata_o <= {mem_byte({addr_i[31:1], 1'b0}), mem_byte({addr_i[31:1], 1'b1})};
      end
    end
  end
endmodule : tx_mem_model
`default_nettype wire
